// >>> design/pfdc_fb_divider.sv
// Purpose: prescaler plus swallow and main feedback counters
// Assumes: oscTick is one mclk-wide pulse per oscillator period
// Notes: division ratio is P*B + A in dual-modulus modes
`default_nettype none
`include "pfdc_params.svh"

module pfdc_fb_divider #(
  parameter int AW = 6,
  parameter int BW = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // link to control side
  pfdc_fb_if.div fb
);

  logic [5:0] preCnt_q, preCnt_d;
  logic [AW-1:0] aRem_q, aRem_d;
  logic [BW-1:0] bCnt_q, bCnt_d;
  logic preOut_q, preOut_d;
  logic aOut_q, aOut_d;
  logic fbOut_q, fbOut_d;
  logic [5:0] baseMod;
  logic [5:0] curMod;
  logic dual;
  logic preTerm;
  logic mainTerm;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    baseMod = pfdc_pkg::pfdc_base_mod(fb.mode);
    dual = pfdc_pkg::pfdc_is_dual(fb.mode);
    // extra count only while swallow cycles remain
    curMod = baseMod + {5'h00, dual && (aRem_q != '0)};
    preTerm = fb.oscTick && (preCnt_q + 6'h01 >= curMod);
    // main value 0 or 1 behaves as divide-by-1
    mainTerm = fb.bypass ||
      ({1'b0, bCnt_q} + {{BW{1'b0}}, 1'b1} >= {1'b0, fb.mainValue});
    preCnt_d = preCnt_q;
    aRem_d = aRem_q;
    bCnt_d = bCnt_q;
    preOut_d = 1'b0;
    aOut_d = 1'b0;
    fbOut_d = 1'b0;
    if (fb.holdReset)
    begin
      // counters parked and reloaded while held
      preCnt_d = 6'h00;
      aRem_d = fb.swallowValue;
      bCnt_d = '0;
    end
    else if (fb.oscTick)
    begin
      preCnt_d = preTerm ? 6'h00 : preCnt_q + 6'h01;
      if (preTerm)
      begin
        preOut_d = 1'b1;
        aOut_d = dual && (aRem_q == {{(AW-1){1'b0}}, 1'b1});
        if (mainTerm)
        begin
          fbOut_d = 1'b1;
          aRem_d = fb.swallowValue;
          bCnt_d = '0;
        end
        else
        begin
          bCnt_d = bCnt_q + {{(BW-1){1'b0}}, 1'b1};
          aRem_d = (aRem_q != '0) ? aRem_q - {{(AW-1){1'b0}}, 1'b1} : aRem_q;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      preCnt_q <= 6'h00;
      aRem_q <= '0;
      bCnt_q <= '0;
      preOut_q <= 1'b0;
      aOut_q <= 1'b0;
      fbOut_q <= 1'b0;
    end
    else
    begin
      preCnt_q <= preCnt_d;
      aRem_q <= aRem_d;
      bCnt_q <= bCnt_d;
      preOut_q <= preOut_d;
      aOut_q <= aOut_d;
      fbOut_q <= fbOut_d;
    end
  end

  assign fb.preOut = preOut_q;
  assign fb.swallowOut = aOut_q;
  assign fb.fbOut = fbOut_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_hold_silences_div: assert property (
    fb.holdReset |=> !fbOut_q && !preOut_q && preCnt_q == 6'h00)
    else $error("feedback divider ran while held in reset");
  a_bypass_each_pre: assert property (
    !fb.holdReset && preTerm && fb.bypass |=> fbOut_q && preOut_q)
    else $error("bypass did not divide by one");
  a_fixed_one_pass: assert property (
    !fb.holdReset && fb.oscTick && fb.mode == pfdc_pkg::PFDC_FD1
    |=> preOut_q)
    else $error("divide-by-1 prescaler missed a tick");
  a_zero_a_base: assert property (
    !fb.holdReset && fb.oscTick && dual && aRem_q == '0 &&
    preCnt_q == baseMod - 6'h01 |=> preOut_q)
    else $error("prescaler did not use base modulus with A zero");
  a_swallow_extra: assert property (
    !fb.holdReset && fb.oscTick && dual && aRem_q != '0 &&
    preCnt_q == baseMod - 6'h01 |=> !preOut_q && preCnt_q == baseMod)
    else $error("prescaler skipped the extra swallow count");
  c_dm3233_fb: cover property (
    fb.mode == pfdc_pkg::PFDC_DM3233 && fbOut_q);
  c_bypass_fb: cover property (fb.bypass && fbOut_q);

endmodule : pfdc_fb_divider

`default_nettype wire

// >>> design/pfdc_fb_if.sv
// Purpose: carrier between control registers and feedback divider
// Assumes: one clock, mclk
// Notes: config flows ctl to div, pulses flow back
`default_nettype none

interface pfdc_fb_if #(
  parameter int AW = 6,
  parameter int BW = 13
);
  pfdc_pkg::pfdc_pmode_e mode;
  logic bypass;
  logic holdReset;
  logic [AW-1:0] swallowValue;
  logic [BW-1:0] mainValue;
  logic oscTick;
  logic preOut;
  logic swallowOut;
  logic fbOut;

  modport ctl (
    output mode, bypass, holdReset, swallowValue, mainValue, oscTick,
    input preOut, swallowOut, fbOut
  );
  modport div (
    input mode, bypass, holdReset, swallowValue, mainValue, oscTick,
    output preOut, swallowOut, fbOut
  );
endinterface : pfdc_fb_if

`default_nettype wire

// >>> design/pfdc_params.svh
// Purpose: constants for the pll feedback divider control block
// Assumes: included by bare name from the divider, control and bench files
// Notes: offsets are byte addresses of the 10-bit configuration space
`ifndef PFDC_PARAMS_SVH
`define PFDC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define PFDC_ADDR_FBCTL 10'h016
`define PFDC_ADDR_STSEL 10'h017
`define PFDC_ADDR_OVR 10'h01D
`define PFDC_RST_FBCTL 8'h06
`define PFDC_RST_STSEL 8'h00
`define PFDC_RST_OVR 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PFDC_BIT_CPMID 7
`define PFDC_BIT_RRST 6
`define PFDC_BIT_ABRST 5
`define PFDC_BIT_ALLRST 4
`define PFDC_BIT_BYP 3
`define PFDC_MODE_HI 2
`define PFDC_MODE_LO 0
`define PFDC_SEL_HI 7
`define PFDC_SEL_LO 2
`define PFDC_BIT_OVR 7

// ----------------------------------------------------------------
// status pin selection codes
// ----------------------------------------------------------------
`define PFDC_SEL_GND 6'h00
`define PFDC_SEL_NDIV 6'h01
`define PFDC_SEL_RDIV 6'h02
`define PFDC_SEL_ADIV 6'h03
`define PFDC_SEL_PRE 6'h04

`endif

// >>> design/pfdc_pkg.sv
// Purpose: types shared by the pll feedback divider control block
// Assumes: nothing
// Notes: prescaler mode codes match the 3-bit mode field
`default_nettype none

package pfdc_pkg;

  // ----------------------------------------------------------------
  // prescaler mode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PFDC_FD1 = 3'h0,
    PFDC_FD2 = 3'h1,
    PFDC_DM23 = 3'h2,
    PFDC_DM45 = 3'h3,
    PFDC_DM89 = 3'h4,
    PFDC_DM1617 = 3'h5,
    PFDC_DM3233 = 3'h6,
    PFDC_FD3 = 3'h7
  } pfdc_pmode_e;

  // base modulus of the prescaler for a mode
  function automatic logic [5:0] pfdc_base_mod(input pfdc_pmode_e m);
    case (m)
      PFDC_FD1: pfdc_base_mod = 6'h01;
      PFDC_FD2: pfdc_base_mod = 6'h02;
      PFDC_DM23: pfdc_base_mod = 6'h02;
      PFDC_DM45: pfdc_base_mod = 6'h04;
      PFDC_DM89: pfdc_base_mod = 6'h08;
      PFDC_DM1617: pfdc_base_mod = 6'h10;
      PFDC_DM3233: pfdc_base_mod = 6'h20;
      default: pfdc_base_mod = 6'h03;
    endcase
  endfunction : pfdc_base_mod

  // dual_modulus_mode versus fixed_divide_mode
  function automatic logic pfdc_is_dual(input pfdc_pmode_e m);
    pfdc_is_dual = !(m == PFDC_FD1 || m == PFDC_FD2 || m == PFDC_FD3);
  endfunction : pfdc_is_dual

endpackage : pfdc_pkg

`default_nettype wire

// >>> design/pfdc_pll_fb_ctl.sv
// Purpose: pll divider reset, bypass, prescaler and status pin control
// Assumes: oscTick and refTick are one-cycle pulses in the mclk domain
// Notes: register port is byte wide, read data one cycle after address
`default_nettype none
`include "pfdc_params.svh"

module pfdc_pll_fb_ctl #(
  parameter int RW = 14,
  parameter int AW = 6,
  parameter int BW = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [9:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  output logic [7:0] regRdata,
  // divider inputs
  input wire logic oscTick,
  input wire logic refTick,
  input wire logic [RW-1:0] refDivValue,
  input wire logic [AW-1:0] swallowValue,
  input wire logic [BW-1:0] mainValue,
  // outputs
  output logic statusPin,
  output logic refDivPulse,
  output logic fbDivPulse,
  output logic cpMidSupply
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] fbCtl_q, fbCtl_d;
  logic [7:0] stSel_q, stSel_d;
  logic [7:0] ovr_q, ovr_d;
  logic [7:0] rdata_q, rdata_d;
  logic [RW-1:0] rCnt_q, rCnt_d;
  logic refOut_q, refOut_d;
  logic pin_q, pin_d;
  logic rHold;
  logic abHold;
  logic [5:0] selCode;

  pfdc_fb_if #(.AW(AW), .BW(BW)) fbLink ();

  always_comb
  begin
    fbCtl_d = fbCtl_q;
    stSel_d = stSel_q;
    ovr_d = ovr_q;
    rdata_d = 8'h00;
    if (regWrite)
    begin
      if (regAddr == `PFDC_ADDR_FBCTL)
      begin
        fbCtl_d = regWdata;
      end
      else if (regAddr == `PFDC_ADDR_STSEL)
      begin
        // a selection written under override is dropped
        if (!ovr_q[`PFDC_BIT_OVR])
        begin
          stSel_d = regWdata;
        end
      end
      else if (regAddr == `PFDC_ADDR_OVR)
      begin
        ovr_d = regWdata;
      end
    end
    if (regAddr == `PFDC_ADDR_FBCTL)
    begin
      rdata_d = fbCtl_q;
    end
    else if (regAddr == `PFDC_ADDR_STSEL)
    begin
      rdata_d = stSel_q;
    end
    else if (regAddr == `PFDC_ADDR_OVR)
    begin
      rdata_d = ovr_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fbCtl_q <= `PFDC_RST_FBCTL;
      stSel_q <= `PFDC_RST_STSEL;
      ovr_q <= `PFDC_RST_OVR;
      rdata_q <= 8'h00;
    end
    else
    begin
      fbCtl_q <= fbCtl_d;
      stSel_q <= stSel_d;
      ovr_q <= ovr_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // reference divider
  // ----------------------------------------------------------------
  assign rHold = fbCtl_q[`PFDC_BIT_RRST] || fbCtl_q[`PFDC_BIT_ALLRST];
  assign abHold = fbCtl_q[`PFDC_BIT_ABRST] || fbCtl_q[`PFDC_BIT_ALLRST];

  always_comb
  begin
    rCnt_d = rCnt_q;
    refOut_d = 1'b0;
    if (rHold)
    begin
      rCnt_d = '0;
    end
    else if (refTick)
    begin
      // a value of 0 or 1 passes every reference tick
      if ({1'b0, rCnt_q} + {{RW{1'b0}}, 1'b1} >= {1'b0, refDivValue})
      begin
        rCnt_d = '0;
        refOut_d = 1'b1;
      end
      else
      begin
        rCnt_d = rCnt_q + {{(RW-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rCnt_q <= '0;
      refOut_q <= 1'b0;
    end
    else
    begin
      rCnt_q <= rCnt_d;
      refOut_q <= refOut_d;
    end
  end

  // ----------------------------------------------------------------
  // feedback divider
  // ----------------------------------------------------------------
  assign fbLink.mode =
    pfdc_pkg::pfdc_pmode_e'(fbCtl_q[`PFDC_MODE_HI:`PFDC_MODE_LO]);
  assign fbLink.bypass = fbCtl_q[`PFDC_BIT_BYP];
  assign fbLink.holdReset = abHold;
  // swallow value trusted to be zero under bypass
  assign fbLink.swallowValue = swallowValue;
  assign fbLink.mainValue = mainValue;
  assign fbLink.oscTick = oscTick;

  pfdc_fb_divider #(.AW(AW), .BW(BW)) u_fbDiv (
    .mclk(mclk),
    .reset_n(reset_n),
    .fb(fbLink.div)
  );

  // ----------------------------------------------------------------
  // status pin
  // ----------------------------------------------------------------
  // pulses shown one mclk wide; references lie outside, so 1xxxxx is low
  assign selCode = stSel_q[`PFDC_SEL_HI:`PFDC_SEL_LO];

  always_comb
  begin
    case (selCode)
      `PFDC_SEL_NDIV: pin_d = fbLink.fbOut;
      `PFDC_SEL_RDIV: pin_d = refOut_q;
      `PFDC_SEL_ADIV: pin_d = fbLink.swallowOut;
      `PFDC_SEL_PRE: pin_d = fbLink.preOut;
      default: pin_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_q <= 1'b0;
    end
    else
    begin
      pin_q <= pin_d;
    end
  end

  assign regRdata = rdata_q;
  assign statusPin = pin_q;
  assign refDivPulse = refOut_q;
  assign fbDivPulse = fbLink.fbOut;
  assign cpMidSupply = fbCtl_q[`PFDC_BIT_CPMID];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_r_hold_quiet: assert property (
    rHold [*2] |-> !refOut_q && rCnt_q == '0)
    else $error("reference divider counted while held");
  a_all_holds_ab: assert property (
    regWrite && regAddr == `PFDC_ADDR_FBCTL &&
    regWdata[`PFDC_BIT_ALLRST] |=> rHold ##1 !fbLink.fbOut)
    else $error("common reset did not hold all counters");
  a_sel_locked: assert property (
    regWrite && regAddr == `PFDC_ADDR_STSEL && ovr_q[`PFDC_BIT_OVR]
    |=> stSel_q == $past(stSel_q))
    else $error("status selection changed under override");
  a_sel_takes: assert property (
    regWrite && regAddr == `PFDC_ADDR_STSEL && !ovr_q[`PFDC_BIT_OVR]
    |=> stSel_q == $past(regWdata))
    else $error("status selection write lost");
  a_pin_follows_n: assert property (
    selCode == `PFDC_SEL_NDIV && $stable(selCode)
    |-> statusPin == $past(fbLink.fbOut))
    else $error("status pin does not follow feedback output");
  a_pin_ground: assert property (
    selCode == `PFDC_SEL_GND |=> !statusPin)
    else $error("status pin not low for ground selection");
  a_mode_reaches_div: assert property (
    regWrite && regAddr == `PFDC_ADDR_FBCTL
    |=> fbLink.mode == $past(regWdata[`PFDC_MODE_HI:`PFDC_MODE_LO]))
    else $error("prescaler mode not applied");
  a_unmapped_zero: assert property (
    regAddr != `PFDC_ADDR_FBCTL && regAddr != `PFDC_ADDR_STSEL &&
    regAddr != `PFDC_ADDR_OVR |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  c_ref_pulse: cover property (refDivPulse);
  c_pin_toggle: cover property (selCode == `PFDC_SEL_PRE && statusPin);
  c_locked_write: cover property (
    regWrite && regAddr == `PFDC_ADDR_STSEL && ovr_q[`PFDC_BIT_OVR]);

endmodule : pfdc_pll_fb_ctl

`default_nettype wire

// >>> test/tb.sv
// Purpose: self-checking bench for the pll feedback divider control block
// Assumes: ticks drawn at random; ratios counted in ticks, not cycles
// Notes: the third pulse after a change is measured, earlier ones may be short
`default_nettype none
`include "pfdc_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic [7:0] regRdata;
  logic oscTick = 1'b0;
  logic refTick = 1'b0;
  logic [13:0] refDivValue = 14'h0003;
  logic [5:0] swallowValue = 6'h00;
  logic [12:0] mainValue = 13'h0003;
  logic statusPin, refDivPulse, fbDivPulse, cpMidSupply;
  int num_errors = 0;
  int n_checks = 0;
  int fbCount = 0, refCount = 0, fbPer = 0, refPer = 0;
  int fbAcc = 0, refAcc = 0, diffFb = 0, diffRef = 0, hiCnt = 0;
  logic prevOsc = 1'b0, prevRef = 1'b0, prevFb = 1'b0, prevRp = 1'b0;
  int diffPre = 0;
  logic prevOsc2 = 1'b0;

  pfdc_pll_fb_ctl dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRdata(regRdata),
    .oscTick(oscTick), .refTick(refTick), .refDivValue(refDivValue),
    .swallowValue(swallowValue), .mainValue(mainValue),
    .statusPin(statusPin), .refDivPulse(refDivPulse),
    .fbDivPulse(fbDivPulse), .cpMidSupply(cpMidSupply));

  always #25 mclk = ~mclk;

  // ----------------------------------------------------------------
  // stimulus and monitors
  // ----------------------------------------------------------------
  // gaps in the ticks show that only ticks, not cycles, are counted
  always @(posedge mclk)
  begin
    oscTick <= ($urandom % 4) != 0;
    refTick <= ($urandom % 4) != 0;
  end

  always @(negedge mclk)
  begin
    if (fbDivPulse === 1'b1)
    begin
      fbPer = fbAcc;
      fbAcc = 0;
      fbCount++;
    end
    if (refDivPulse === 1'b1)
    begin
      refPer = refAcc;
      refAcc = 0;
      refCount++;
    end
    fbAcc += prevOsc;
    refAcc += prevRef;
    // prescaler output reaches the pin two edges after its tick
    diffPre += (statusPin !== prevOsc2);
    prevOsc2 = prevOsc;
    prevOsc = oscTick;
    prevRef = refTick;
    diffFb += (statusPin !== prevFb);
    diffRef += (statusPin !== prevRp);
    hiCnt += (statusPin !== 1'b0);
    prevFb = fbDivPulse;
    prevRp = refDivPulse;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    @(posedge mclk);
    @(negedge mclk);
    chk("regRdata", {24'h0, e}, {24'h0, regRdata});
  endtask : rd

  // waits for three fresh pulses so a partial first period is skipped
  task automatic settle(input int n0, input bit isRef);
    int k;
    for (k = 0; k < 20000; k++)
    begin
      @(negedge mclk);
      if ((isRef ? refCount : fbCount) >= n0 + 3)
        break;
    end
    if ((isRef ? refCount : fbCount) < n0 + 3)
      chk("pulse count", n0 + 3, isRef ? refCount : fbCount);
  endtask : settle

  function automatic int expN(input int m, input int a, input int b,
                              input bit byp);
    int p;
    case (m)
      0: p = 1;
      1: p = 2;
      2: p = 2;
      3: p = 4;
      4: p = 8;
      5: p = 16;
      6: p = 32;
      default: p = 3;
    endcase
    if (byp)
      return p;
    if (m == 0 || m == 1 || m == 7)
      return p * b;
    return p * b + a;
  endfunction : expN

  task automatic final_report;
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  initial
  begin
    #(50 * 95000);
    num_errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int m, k, a, b, f0, r0, bt;
    logic [7:0] v;
    void'($urandom(27143));
    repeat (8) @(posedge mclk);
    chk("fbDivPulse in reset", 32'h0, {31'h0, fbDivPulse});
    chk("statusPin in reset", 32'h0, {31'h0, statusPin});
    reset_n <= 1'b1;
    rd(`PFDC_ADDR_FBCTL, `PFDC_RST_FBCTL);
    rd(`PFDC_ADDR_STSEL, `PFDC_RST_STSEL);
    rd(`PFDC_ADDR_OVR, `PFDC_RST_OVR);
    wr(10'h3FF, 8'hA5);
    rd(10'h3FF, 8'h00);
    v = 8'($urandom);
    wr(`PFDC_ADDR_FBCTL, v);
    rd(`PFDC_ADDR_FBCTL, v);
    chk("cpMidSupply", {31'h0, v[7]}, {31'h0, cpMidSupply});
    wr(`PFDC_ADDR_FBCTL, v ^ 8'h80);
    @(negedge mclk);
    chk("cpMidSupply", {31'h0, ~v[7]}, {31'h0, cpMidSupply});
    // every mode: A zero, A nonzero, then bypass with A zero
    for (m = 0; m < 8; m++)
      for (k = 0; k < 3; k++)
      begin
        b = 2 + $urandom % 5;
        a = (k == 1) ? 1 + $urandom % (b - 1) : 0;
        @(posedge mclk);
        mainValue <= 13'(b);
        swallowValue <= 6'(a);
        wr(`PFDC_ADDR_FBCTL, {4'h0, k == 2, 3'(m)});
        settle(fbCount, 1'b0);
        chk("fb ratio", expN(m, a, b, k == 2), fbPer);
      end
    // counter holds
    @(posedge mclk);
    mainValue <= 13'h0003;
    swallowValue <= 6'h00;
    refDivValue <= 14'h0003;
    wr(`PFDC_ADDR_FBCTL, 8'h01);
    settle(refCount, 1'b1);
    chk("ref ratio", 32'd3, refPer);
    for (bt = 4; bt < 7; bt++)
    begin
      wr(`PFDC_ADDR_FBCTL, 8'h01 | (8'h01 << bt));
      repeat (3) @(posedge mclk);
      f0 = fbCount;
      r0 = refCount;
      repeat (100) @(posedge mclk);
      chk("fb runs", {31'h0, bt == 6}, {31'h0, fbCount > f0});
      chk("ref runs", {31'h0, bt == 5}, {31'h0, refCount > r0});
      wr(`PFDC_ADDR_FBCTL, 8'h01);
    end
    // status selections: ground, fb, ref, upper ground, prescaler
    // divide-by-1 prescaler so its output pulses on every tick
    wr(`PFDC_ADDR_FBCTL, 8'h00);
    for (k = 0; k < 5; k++)
    begin
      v = (k == 3) ? 8'h80 : 8'(k << 2);
      wr(`PFDC_ADDR_STSEL, v);
      repeat (4) @(posedge mclk);
      diffFb = 0;
      diffRef = 0;
      hiCnt = 0;
      diffPre = 0;
      repeat (150) @(posedge mclk);
      if (k == 1)
        chk("status follows fb", 32'h0, diffFb);
      else if (k == 2)
        chk("status follows ref", 32'h0, diffRef);
      else if (k == 4)
        chk("status follows pre", 32'h0, diffPre);
      else
        chk("status ground", 32'h0, hiCnt);
    end
    // override set: selection write dropped
    wr(`PFDC_ADDR_STSEL, 8'h04);
    wr(`PFDC_ADDR_OVR, 8'h80);
    wr(`PFDC_ADDR_STSEL, 8'h08);
    rd(`PFDC_ADDR_STSEL, 8'h04);
    wr(`PFDC_ADDR_OVR, 8'h00);
    wr(`PFDC_ADDR_STSEL, 8'h08);
    rd(`PFDC_ADDR_STSEL, 8'h08);
    final_report();
  end
endmodule : tb

`default_nettype wire
